// file: logic/sfpf_core.sv
// serial flash front end: frame decode, protection, secure otp locks
// assumes the array engine sits on clk_sys and answers reads one cycle after a request
// Operation
// - top/bottom one: level n protects lowest blocks
// - levels ten to fifteen protect everything
// - top/bottom zero: level n protects highest blocks
// - separate 4K-bit one-time area for serial
// - security bit zero shows factory lock
// - security write sets customer lock bit one
// - locks once set never clear again
// - otp mode refuses main array access
// - serial field low, customer field above
// - sectors of 4K in 64K blocks
// - end blocks lock per 4K sector
// - bad opcode: standby, output off, until select
// - good opcode: active until select rises
// - sample on clock rise, shift on fall
// - clock modes zero and three only
// - reads end at once on select rise
// - write-type commands need byte-aligned select rise
// - array access ignored while busy; a running read still fetches each next byte
// - writes need write enable latch set
module sfpf_core (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic si_pin,
    input wire logic factory_lock_strap,
    input wire logic tb_sel,
    input wire logic [31:0] sector_lock,
    input wire logic array_busy,
    input wire logic [7:0] rd_data,
    output logic so_out,
    output logic so_oe,
    output sfpf_pkg::sfpf_req_t req,
    output logic active,
    output logic write_enable_latch,
    output logic otp_mode,
    output logic quad_mode,
    output logic factory_lock,
    output logic customer_lock,
    output logic [3:0] protect_level
);
    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    sfpf_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_async({factory_lock_strap, si_pin, sclk_pin, cs_n_pin}),
        .rst_level(4'h1),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    sfpf_pkg::sfpf_state_t state_reg;
    sfpf_pkg::sfpf_state_t state_next;
    logic [5:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] cmd_reg;
    logic [31:0] addr_reg;
    logic [7:0] data_reg;
    logic [7:0] out_sh_reg;
    logic [2:0] out_cnt_reg;
    logic load_pend_reg;
    logic so_reg;
    logic so_oe_reg;
    logic active_reg;
    logic wel_reg;
    logic otp_reg;
    logic quad_reg;
    logic flock_reg;
    logic clock_reg;
    logic [3:0] level_reg;
    sfpf_pkg::sfpf_req_t req_reg;
    sfpf_pkg::sfpf_req_t req_next;

    // link events, all from the synchronised copies
    logic cs_n;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si;
    logic strap;
    assign cs_n = pin_level[0];
    assign cs_fall = pin_fall[0];
    assign cs_rise = pin_rise[0];
    // idle level ignored; only edges inside the frame
    assign sck_rise = pin_rise[1] & ~cs_n;
    assign sck_fall = pin_fall[1] & ~cs_n;
    assign si = pin_level[2];
    assign strap = pin_level[3];

    logic [7:0] sh_next;
    logic byte_done;
    logic [5:0] cnt_inc;
    assign sh_next = {shift_reg[6:0], si};
    assign cnt_inc = (bit_cnt_reg == 6'h3F) ? bit_cnt_reg : bit_cnt_reg + 6'h01;
    assign byte_done = sck_rise & (cnt_inc[2:0] == 3'h0);

    function automatic logic op_valid(input logic [7:0] op);
        case (op)
            sfpf_pkg::OP_WRITE_LATCH_SET, sfpf_pkg::OP_WRITE_LATCH_CLR,
            sfpf_pkg::OP_STATUS_READ, sfpf_pkg::OP_STATUS_WRITE,
            sfpf_pkg::OP_SECURITY_READ, sfpf_pkg::OP_SECURITY_WRITE,
            sfpf_pkg::OP_OTP_ENTER, sfpf_pkg::OP_OTP_EXIT,
            sfpf_pkg::OP_QUAD_ENTER, sfpf_pkg::OP_QUAD_EXIT,
            sfpf_pkg::OP_READ, sfpf_pkg::OP_PROGRAM,
            sfpf_pkg::OP_ERASE_SECTOR, sfpf_pkg::OP_ERASE_BLOCK: op_valid = 1'b1;
            default: op_valid = 1'b0;
        endcase
    endfunction

    function automatic logic op_has_addr(input logic [7:0] op);
        op_has_addr = (op == sfpf_pkg::OP_READ) || (op == sfpf_pkg::OP_PROGRAM) ||
                      (op == sfpf_pkg::OP_ERASE_SECTOR) || (op == sfpf_pkg::OP_ERASE_BLOCK);
    endfunction

    // status and security bytes
    logic [7:0] status_byte;
    logic [7:0] security_byte;
    assign status_byte = {2'b00, level_reg, wel_reg, array_busy};
    assign security_byte = {6'h00, clock_reg, flock_reg};

    // 25-bit byte address, 512 blocks of 16 sectors
    logic [sfpf_pkg::ADDR_W-1:0] tgt_addr;
    logic arr_prot;
    assign tgt_addr = addr_reg[sfpf_pkg::ADDR_W-1:0];

    sfpf_protect u_protect (
        .addr(tgt_addr),
        .level(level_reg),
        .tb_sel(tb_sel),
        .sector_lock(sector_lock),
        .whole_block(cmd_reg == sfpf_pkg::OP_ERASE_BLOCK),
        .prot(arr_prot)
    );

    // serial field under factory lock, rest under customer lock
    logic otp_prot;
    assign otp_prot = (addr_reg[sfpf_pkg::OTP_AW-1:0] <= sfpf_pkg::OTP_SERIAL_LAST) ?
                      flock_reg : clock_reg;

    // write-type commands run only on an aligned select rise
    logic aligned;
    logic ex_ok;
    assign aligned = cs_rise & (bit_cnt_reg[2:0] == 3'h0) & (state_reg != sfpf_pkg::SFPF_STBY);
    assign ex_ok = aligned & (state_reg != sfpf_pkg::SFPF_IDLE);
    logic ex_wrl_set;
    logic ex_wrl_clr;
    logic ex_sr_wr;
    logic ex_sec_wr;
    logic ex_otp_in;
    logic ex_otp_out;
    logic ex_q_in;
    logic ex_q_out;
    logic ex_prog;
    logic ex_erase;
    logic one_byte;
    assign one_byte = ex_ok & (bit_cnt_reg == sfpf_pkg::BITS_CMD);
    assign ex_wrl_set = one_byte & (cmd_reg == sfpf_pkg::OP_WRITE_LATCH_SET);
    assign ex_wrl_clr = one_byte & (cmd_reg == sfpf_pkg::OP_WRITE_LATCH_CLR);
    assign ex_otp_in = one_byte & (cmd_reg == sfpf_pkg::OP_OTP_ENTER);
    assign ex_otp_out = one_byte & (cmd_reg == sfpf_pkg::OP_OTP_EXIT);
    assign ex_q_in = one_byte & (cmd_reg == sfpf_pkg::OP_QUAD_ENTER);
    assign ex_q_out = one_byte & (cmd_reg == sfpf_pkg::OP_QUAD_EXIT);
    assign ex_sec_wr = one_byte & (cmd_reg == sfpf_pkg::OP_SECURITY_WRITE) & wel_reg &
                       ~array_busy;
    assign ex_sr_wr = ex_ok & (bit_cnt_reg == sfpf_pkg::BITS_STATUS_WRITE) &
                      (cmd_reg == sfpf_pkg::OP_STATUS_WRITE) & wel_reg & ~array_busy;
    assign ex_prog = ex_ok & (bit_cnt_reg == sfpf_pkg::BITS_PROGRAM) &
                     (cmd_reg == sfpf_pkg::OP_PROGRAM) & wel_reg & ~array_busy &
                     ~(otp_reg ? otp_prot : arr_prot);
    assign ex_erase = ex_ok & (bit_cnt_reg == sfpf_pkg::BITS_ADDR_END) &
                      ((cmd_reg == sfpf_pkg::OP_ERASE_SECTOR) |
                       (cmd_reg == sfpf_pkg::OP_ERASE_BLOCK)) &
                      wel_reg & ~array_busy & ~otp_reg & ~arr_prot;

    // read start and byte reload
    logic addr_done;
    logic rd_start;
    logic rd_refused;
    logic out_byte_end;
    logic rd_next;
    assign addr_done = byte_done & (state_reg == sfpf_pkg::SFPF_ADDR) &
                       (cnt_inc == sfpf_pkg::BITS_ADDR_END);
    assign rd_start = addr_done & (cmd_reg == sfpf_pkg::OP_READ) & ~array_busy;
    assign rd_refused = addr_done & (cmd_reg == sfpf_pkg::OP_READ) & array_busy;
    assign out_byte_end = sck_fall & (state_reg == sfpf_pkg::SFPF_DOUT) & (out_cnt_reg == 3'h7);
    assign rd_next = out_byte_end & (cmd_reg == sfpf_pkg::OP_READ);

    // frame state machine
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sfpf_pkg::SFPF_IDLE:
                state_next = sfpf_pkg::SFPF_IDLE;
            sfpf_pkg::SFPF_CMD:
                if (byte_done)
                begin
                    if (!op_valid(sh_next))
                        state_next = sfpf_pkg::SFPF_STBY;
                    else if (op_has_addr(sh_next))
                        state_next = sfpf_pkg::SFPF_ADDR;
                    else if (sh_next == sfpf_pkg::OP_STATUS_READ ||
                             sh_next == sfpf_pkg::OP_SECURITY_READ)
                        state_next = sfpf_pkg::SFPF_DOUT;
                    else if (sh_next == sfpf_pkg::OP_STATUS_WRITE)
                        state_next = sfpf_pkg::SFPF_DIN;
                    else
                        state_next = sfpf_pkg::SFPF_WAIT;
                end
            sfpf_pkg::SFPF_ADDR:
                if (rd_start)
                    state_next = sfpf_pkg::SFPF_DOUT;
                else if (rd_refused)
                    state_next = sfpf_pkg::SFPF_STBY;
                else if (addr_done)
                    state_next = (cmd_reg == sfpf_pkg::OP_PROGRAM) ?
                                 sfpf_pkg::SFPF_DIN : sfpf_pkg::SFPF_WAIT;
            sfpf_pkg::SFPF_DIN:
                if (byte_done)
                    state_next = sfpf_pkg::SFPF_WAIT;
            sfpf_pkg::SFPF_DOUT:
                state_next = sfpf_pkg::SFPF_DOUT;
            sfpf_pkg::SFPF_WAIT:
                state_next = sfpf_pkg::SFPF_WAIT;
            sfpf_pkg::SFPF_STBY:
                state_next = sfpf_pkg::SFPF_STBY;
            default:
                state_next = sfpf_pkg::SFPF_IDLE;
        endcase
        // select rise ends any frame at once
        if (cs_rise)
            state_next = sfpf_pkg::SFPF_IDLE;
        else if (cs_fall)
            state_next = sfpf_pkg::SFPF_CMD;
    end

    // request toward the array engine
    always_comb
    begin
        req_next = '0;
        req_next.otp = otp_reg;
        req_next.addr = tgt_addr;
        req_next.data = data_reg;
        if (rd_start || rd_next)
        begin
            req_next.valid = 1'b1;
            req_next.kind = sfpf_pkg::SFPF_REQ_READ;
            req_next.addr = rd_start ? {addr_reg[sfpf_pkg::ADDR_W-9:0], sh_next} :
                            tgt_addr + 25'h0000001;
        end
        else if (ex_prog)
        begin
            req_next.valid = 1'b1;
            req_next.kind = sfpf_pkg::SFPF_REQ_PROG;
        end
        else if (ex_erase)
        begin
            req_next.valid = 1'b1;
            req_next.kind = (cmd_reg == sfpf_pkg::OP_ERASE_BLOCK) ?
                            sfpf_pkg::SFPF_REQ_ERASE_BLK : sfpf_pkg::SFPF_REQ_ERASE_SEC;
        end
    end

    // frame shifting and counters
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_reg <= sfpf_pkg::SFPF_IDLE;
            bit_cnt_reg <= 6'h00;
            shift_reg <= sfpf_pkg::BYTE_RST;
            cmd_reg <= sfpf_pkg::BYTE_RST;
            addr_reg <= 32'h00000000;
            data_reg <= sfpf_pkg::BYTE_RST;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            if (cs_fall)
                bit_cnt_reg <= 6'h00;
            else if (sck_rise)
            begin
                bit_cnt_reg <= cnt_inc;
                shift_reg <= sh_next;
            end
            if (byte_done && state_reg == sfpf_pkg::SFPF_CMD)
                cmd_reg <= sh_next;
            if (byte_done && state_reg == sfpf_pkg::SFPF_ADDR)
                addr_reg <= {addr_reg[23:0], sh_next};
            else if (rd_next)
                addr_reg <= addr_reg + 32'h00000001;
            if (byte_done && state_reg == sfpf_pkg::SFPF_DIN)
                data_reg <= sh_next;
        end
    end

    // output shifts on the falling clock
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            out_sh_reg <= sfpf_pkg::BYTE_RST;
            out_cnt_reg <= 3'h0;
            load_pend_reg <= 1'b0;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
            active_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            load_pend_reg <= req_reg.valid & (req_reg.kind == sfpf_pkg::SFPF_REQ_READ);
            if (load_pend_reg)
                out_sh_reg <= rd_data;
            else if (byte_done && state_reg == sfpf_pkg::SFPF_CMD)
                out_sh_reg <= (sh_next == sfpf_pkg::OP_SECURITY_READ) ? security_byte :
                              status_byte;
            else if (out_byte_end && cmd_reg != sfpf_pkg::OP_READ)
                out_sh_reg <= (cmd_reg == sfpf_pkg::OP_SECURITY_READ) ? security_byte :
                              status_byte;
            else if (sck_fall && state_reg == sfpf_pkg::SFPF_DOUT)
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            if (cs_fall)
                out_cnt_reg <= 3'h0;
            else if (sck_fall && state_reg == sfpf_pkg::SFPF_DOUT)
            begin
                out_cnt_reg <= out_cnt_reg + 3'h1;
                so_reg <= out_sh_reg[7];
            end
            so_oe_reg <= (state_next == sfpf_pkg::SFPF_DOUT);
            // active from valid opcode to select rise
            if (cs_rise || cs_fall)
                active_reg <= 1'b0;
            else if (byte_done && state_reg == sfpf_pkg::SFPF_CMD)
                active_reg <= op_valid(sh_next);
        end
    end

    // latches, modes and locks
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wel_reg <= 1'b0;
            otp_reg <= 1'b0;
            quad_reg <= 1'b0;
            flock_reg <= 1'b0;
            clock_reg <= 1'b0;
            level_reg <= sfpf_pkg::LEVEL_RST;
            req_reg <= '0;
        end
        else if (clk_en)
        begin
            req_reg <= req_next;
            if (ex_wrl_set)
                wel_reg <= 1'b1;
            else if (ex_wrl_clr || ex_sr_wr || ex_sec_wr || ex_prog || ex_erase)
                wel_reg <= 1'b0;
            if (ex_otp_in)
                otp_reg <= 1'b1;
            else if (ex_otp_out)
                otp_reg <= 1'b0;
            if (ex_q_in)
                quad_reg <= 1'b1;
            else if (ex_q_out)
                quad_reg <= 1'b0;
            if (strap)
                flock_reg <= 1'b1;
            if (ex_sec_wr)
                clock_reg <= 1'b1;
            if (ex_sr_wr)
                level_reg <= data_reg[sfpf_pkg::SR_LEVEL_LO+3:sfpf_pkg::SR_LEVEL_LO];
        end
    end

    assign so_out = so_reg;
    assign so_oe = so_oe_reg;
    assign req = req_reg;
    assign active = active_reg;
    assign write_enable_latch = wel_reg;
    assign otp_mode = otp_reg;
    assign quad_mode = quad_reg;
    assign factory_lock = flock_reg;
    assign customer_lock = clock_reg;
    assign protect_level = level_reg;
endmodule

// file: logic/sfpf_pkg.sv
// constants, request carrier and state codes of the serial flash front end
// assumes one system clock; the link pins are sampled, never used as clocks
package sfpf_pkg;

    // clock and link timing
    localparam int CLK_SYS_NS = 100;
    localparam int SCLK_MIN_PERIOD_NS = 800;
    localparam int SYS_PER_SCLK = SCLK_MIN_PERIOD_NS / CLK_SYS_NS;

    // array geometry
    localparam int ADDR_W = 25;
    localparam int BLK_W = 9;
    localparam int NUM_BLK = 512;
    localparam int SEC_PER_BLK = 16;
    localparam int OTP_AW = 9;
    localparam logic [8:0] OTP_SERIAL_LAST = 9'h00F;
    localparam logic [3:0] LEVEL_ALL = 4'hA;

    // opcodes of the frame decoder
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_SECURITY_READ = 8'h2B;
    localparam logic [7:0] OP_SECURITY_WRITE = 8'h2F;
    localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
    localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
    localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
    localparam logic [7:0] OP_QUAD_EXIT = 8'hF5;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_SECTOR = 8'h20;
    localparam logic [7:0] OP_ERASE_BLOCK = 8'hD8;

    // frame lengths in bits
    localparam logic [5:0] BITS_CMD = 6'h08;
    localparam logic [5:0] BITS_STATUS_WRITE = 6'h10;
    localparam logic [5:0] BITS_ADDR_END = 6'h28;
    localparam logic [5:0] BITS_PROGRAM = 6'h30;

    // status byte and security byte fields
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_LEVEL_LO = 2;
    localparam int SEC_FACTORY = 0;
    localparam int SEC_CUSTOMER = 1;

    // reset values
    localparam logic [3:0] LEVEL_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        SFPF_REQ_READ = 2'b00,
        SFPF_REQ_PROG = 2'b01,
        SFPF_REQ_ERASE_SEC = 2'b10,
        SFPF_REQ_ERASE_BLK = 2'b11
    } sfpf_req_kind_t;

    typedef struct packed {
        logic valid;
        sfpf_req_kind_t kind;
        logic otp;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } sfpf_req_t;

    typedef enum logic [2:0] {
        SFPF_IDLE = 3'b000,
        SFPF_CMD = 3'b001,
        SFPF_ADDR = 3'b010,
        SFPF_DIN = 3'b011,
        SFPF_DOUT = 3'b100,
        SFPF_WAIT = 3'b101,
        SFPF_STBY = 3'b110
    } sfpf_state_t;

endpackage

// file: logic/sfpf_protect.sv
// write-protect decode for one address
// assumes level and sector locks are stable while decoded
module sfpf_protect (
    input wire logic [sfpf_pkg::ADDR_W-1:0] addr,
    input wire logic [3:0] level,
    input wire logic tb_sel,
    input wire logic [31:0] sector_lock,
    input wire logic whole_block,
    output logic prot
);
    logic [sfpf_pkg::BLK_W-1:0] blk;
    logic [3:0] sec;
    logic [9:0] span;
    logic bottom_hit;
    logic top_hit;
    logic level_hit;
    logic sec_hit;

    assign blk = addr[sfpf_pkg::ADDR_W-1:16];
    assign sec = addr[15:12];
    assign span = 10'h001 << (level - 4'h1);
    assign bottom_hit = {1'b0, blk} < span;
    assign top_hit = {1'b0, blk} >= (10'(sfpf_pkg::NUM_BLK) - span);
    assign level_hit = (level == 4'h0) ? 1'b0 :
                       (level >= sfpf_pkg::LEVEL_ALL) ? 1'b1 :
                       (tb_sel ? bottom_hit : top_hit);
    assign sec_hit = (blk == 9'h000) ? (whole_block ? |sector_lock[15:0] : sector_lock[sec]) :
                     (blk == 9'h1FF) ? (whole_block ? |sector_lock[31:16] :
                                        sector_lock[5'h10 + {1'b0, sec}]) : 1'b0;
    assign prot = level_hit | sec_hit;
endmodule

// file: logic/sfpf_sync.sv
// two-flop synchroniser with edge flags for the link pins
// assumes the inputs are asynchronous to clk_sys
module sfpf_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [W-1:0] pin_async,
    input wire logic [W-1:0] rst_level,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_reg <= rst_level;
            sync_reg <= rst_level;
            prev_reg <= rst_level;
        end
        else if (clk_en)
        begin
            meta_reg <= pin_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // edges seen only after reset settles; prev mirrors sync
    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
endmodule

// file: test/sfpf_core_bench.sv
// self-checking bench of the serial flash front end
// assumes a 10 MHz clk_sys and the host model on the link pins
module sfpf_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic factory_lock_strap = 1'b0;
    logic tb_sel = 1'b1;
    logic array_busy = 1'b0;
    logic [31:0] sector_lock = 32'h0;
    logic [7:0] rd_data = 8'h00;
    logic cs_n_pin, sclk_pin, si_pin, so_out, so_oe, active, write_enable_latch;
    logic otp_mode, quad_mode, factory_lock, customer_lock;
    logic [3:0] protect_level;
    sfpf_pkg::sfpf_req_t req;
    int n_fail = 0;
    int cmp_count = 0;
    int n_wr = 0;
    wire logic so_pin = so_oe ? so_out : 1'bz;
    always #50 clk_sys = ~clk_sys;
    sfpf_host u_sfpf_host (.cs_n(cs_n_pin), .sclk(sclk_pin), .si(si_pin), .so(so_pin));
    sfpf_core u_sfpf_core (.clk_sys, .sys_rst, .clk_en(1'b1), .cs_n_pin, .sclk_pin, .si_pin,
        .factory_lock_strap, .tb_sel, .sector_lock, .array_busy, .rd_data, .so_out, .so_oe,
        .req, .active, .write_enable_latch, .otp_mode, .quad_mode, .factory_lock,
        .customer_lock, .protect_level);
    always @(posedge clk_sys)
    begin
        if (req.valid && req.kind != sfpf_pkg::SFPF_REQ_READ)
            n_wr <= n_wr + 1;
        if (req.valid)
            rd_data <= req.addr[7:0] ^ 8'h5A;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] op, input logic [39:0] rest, input int n);
        logic [7:0] r;
        u_sfpf_host.xfer({op, rest}, n, 0, r);
    endtask
    task automatic write_latch_set_cmd;
        send(sfpf_pkg::OP_WRITE_LATCH_SET, 40'h0, 8);
    endtask
    task automatic level(input logic [3:0] lv);
        write_latch_set_cmd;
        send(sfpf_pkg::OP_STATUS_WRITE, {2'b00, lv, 34'h0}, 16);
    endtask
    task automatic prog(input logic [7:0] op, input logic [24:0] a, input int ok);
        int n0;
        n0 = n_wr;
        write_latch_set_cmd;
        send(op, {7'h00, a, 8'hA5}, (op == sfpf_pkg::OP_PROGRAM) ? 48 : 40);
        chk(n_wr - n0, ok);
    endtask
    task automatic t_frame;
        send(sfpf_pkg::OP_WRITE_LATCH_SET, 40'h0, 9);
        chk(write_enable_latch, 0);
        send(8'hFF, 40'h0, 16);
        chk({active, so_oe}, 0);
        u_sfpf_host.mode3 = 1'b1;
        fork
            write_latch_set_cmd;
            begin
                repeat (74) @(posedge clk_sys);
                chk(active, 1);
            end
        join
        chk(write_enable_latch, 1);
        u_sfpf_host.mode3 = 1'b0;
        chk(active, 0);
        send(sfpf_pkg::OP_QUAD_ENTER, 40'h0, 8);
        chk(quad_mode, 1);
        send(sfpf_pkg::OP_QUAD_EXIT, 40'h0, 8);
        chk(quad_mode, 0);
    endtask
    task automatic t_levels;
        int b;
        for (int t = 0; t < 2; t++)
        begin
            @(posedge clk_sys) tb_sel <= t[0];
            for (int lv = 0; lv < 12; lv++)
            begin
                level(lv[3:0]);
                chk(protect_level, lv);
                b = (lv == 0) ? 0 : (1 << ((lv > 9 ? 9 : lv) - 1));
                for (int k = b - 1; k <= b; k++)
                    if (k >= 0)
                        prog(sfpf_pkg::OP_PROGRAM, {t[0] ? k[8:0] : 9'h1FF - k[8:0], 16'h8000},
                            lv < 10 && k >= b);
            end
        end
    endtask
    task automatic t_sector;
        level(4'h0);
        @(posedge clk_sys) sector_lock <= 32'h8000_0008;
        prog(sfpf_pkg::OP_PROGRAM, 25'h0003000, 0);
        prog(sfpf_pkg::OP_PROGRAM, 25'h0004000, 1);
        prog(sfpf_pkg::OP_ERASE_SECTOR, 25'h1FFF000, 0);
        prog(sfpf_pkg::OP_PROGRAM, 25'h1FFE000, 1);
        @(posedge clk_sys) array_busy <= 1'b1;
        prog(sfpf_pkg::OP_PROGRAM, 25'h0004000, 0);
        @(posedge clk_sys) array_busy <= 1'b0;
    endtask
    task automatic t_read;
        logic [7:0] r;
        u_sfpf_host.xfer({sfpf_pkg::OP_STATUS_READ, 40'h0}, 8, 8, r);
        chk(r, 8'h02);
        u_sfpf_host.xfer({sfpf_pkg::OP_READ, 32'h0000_1234, 8'h00}, 40, 16, r);
        chk(r, 8'h6F);
        chk(so_oe, 0);
    endtask
    task automatic t_otp;
        logic [7:0] r;
        @(posedge clk_sys) factory_lock_strap <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(factory_lock, 1);
        write_latch_set_cmd;
        send(sfpf_pkg::OP_OTP_ENTER, 40'h0, 8);
        chk(otp_mode, 1);
        prog(sfpf_pkg::OP_PROGRAM, 25'h0000010, 1);
        prog(sfpf_pkg::OP_PROGRAM, 25'h000000F, 0);
        prog(sfpf_pkg::OP_ERASE_SECTOR, 25'h0100000, 0);
        write_latch_set_cmd;
        send(sfpf_pkg::OP_SECURITY_WRITE, 40'h0, 8);
        chk(customer_lock, 1);
        prog(sfpf_pkg::OP_PROGRAM, 25'h0000020, 0);
        write_latch_set_cmd;
        send(sfpf_pkg::OP_OTP_EXIT, 40'h0, 8);
        chk(otp_mode, 0);
        @(posedge clk_sys) factory_lock_strap <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk({factory_lock, customer_lock}, 2'b11);
        u_sfpf_host.xfer({sfpf_pkg::OP_SECURITY_READ, 40'h0}, 8, 8, r);
        chk(r, 8'h03);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk({write_enable_latch, otp_mode, customer_lock, protect_level}, 0);
        t_frame;
        t_levels;
        t_sector;
        t_read;
        t_otp;
        end_sim;
    end
    initial
    begin
        #10000000;
        n_fail++;
        end_sim;
    end
endmodule

// file: test/sfpf_core_checker.sv
// port assertions of the serial flash front end
// assumes sys_rst is synchronous to clk_sys
module sfpf_core_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cs_n_pin,
    input wire logic tb_sel,
    input wire logic so_oe,
    input wire sfpf_pkg::sfpf_req_t req,
    input wire logic active,
    input wire logic write_enable_latch,
    input wire logic otp_mode,
    input wire logic factory_lock,
    input wire logic customer_lock,
    input wire logic [3:0] protect_level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic wr_req = req.valid && req.kind != sfpf_pkg::SFPF_REQ_READ && !req.otp;
    wire logic [9:0] blk = {1'b0, req.addr[24:16]};
    wire logic [9:0] span = 10'h001 << (protect_level - 4'h1);
    wire logic mid = protect_level inside {[4'h1:4'h9]};
    a_factory_stays: assert property (factory_lock |=> factory_lock)
        else $error("factory lock cleared");
    a_customer_stays: assert property (customer_lock |=> customer_lock)
        else $error("customer lock cleared");
    a_bottom_guard: assert property (wr_req && tb_sel && mid |-> blk >= span)
        else $error("write into protected low blocks");
    a_top_guard: assert property (wr_req && !tb_sel && mid |-> blk < 10'h200 - span)
        else $error("write into protected high blocks");
    a_all_guard: assert property (wr_req |-> protect_level < 4'hA)
        else $error("write with whole array protected");
    a_otp_only: assert property (req.valid && otp_mode |-> req.otp && !req.kind[1])
        else $error("array access in otp mode");
    a_latch_needed: assert property (wr_req |-> $past(write_enable_latch))
        else $error("write without latch");
    a_lock_latch: assert property ($rose(customer_lock) |-> $past(write_enable_latch))
        else $error("customer lock without latch");
    a_out_released: assert property (cs_n_pin [*8] |-> !so_oe)
        else $error("output enabled while deselected");
    a_idle_inactive: assert property (cs_n_pin [*8] |-> !active)
        else $error("active while deselected");
    cover property (wr_req);
    cover property (req.valid && req.otp);
    cover property ($rose(customer_lock));
endmodule
bind sfpf_core sfpf_core_checker u_sfpf_core_checker (.clk_sys, .sys_rst, .cs_n_pin, .tb_sel,
    .so_oe, .req, .active, .write_enable_latch, .otp_mode, .factory_lock, .customer_lock,
    .protect_level);

// file: test/sfpf_host.sv
// host controller model driving the link pins in clock mode 0 or 3
// assumes the bench calls xfer one frame at a time
module sfpf_host (
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mode3 = 1'b0;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic xfer(input logic [47:0] b, input int n, input int nrd, output logic [7:0] rd);
        sclk <= mode3;
        #400 cs_n <= 1'b0;
        #400;
        for (int i = 0; i < n + nrd; i++)
        begin
            sclk <= 1'b0;
            si <= (i < n) ? b[47-i] : ~si;
            #400 sclk <= 1'b1;
            if (i >= n)
                rd = {rd[6:0], so};
            #400;
        end
        sclk <= mode3;
        #400 cs_n <= 1'b1;
        si <= ~si;
        #800;
    endtask
endmodule
